// >>> rtl/nfc_ctrl.sv
`timescale 1ns/1ps
`include "nfc_map.svh"
// apb slave: conf/cmd/addr/data/ecc/status at 0x000.., boot buffer at 0x1000..0x1fff
module nfc_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [12:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  input  wire logic [1:0]  i_psize,
  input  wire logic        i_big_endian,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_flash_type_strap,
  input  wire logic        i_page_size_strap,
  input  wire logic        i_addr_cycle_strap,
  input  wire logic        i_bus_width_strap,
  input  wire logic [1:0]  i_boot_mode_pins,
  input  wire logic        i_flash_ready_busy,
  input  wire logic [15:0] i_flash_data,
  output logic      [15:0] o_flash_data,
  output logic             o_flash_data_oe,
  output logic             o_cmd_latch,
  output logic             o_addr_latch,
  output logic             o_flash_write_strobe_n,
  output logic             o_flash_read_strobe_n,
  output logic             o_flash_chip_enable_n,
  output logic             o_boot_done,
  output logic             o_irq
);
  logic        cap_ff;
  logic [3:0]  strap_ff;
  logic [1:0]  bmode_ff;
  logic [31:0] conf_ff;
  logic [1:0]  stat_ff;
  logic [1:0]  mask_ff;
  logic        rdy_d_ff;
  logic [31:0] buf_ff [`NFC_BUF_WORDS];
  nfc_pkg::nfc_state_e st_ff;
  nfc_pkg::nfc_cyc_e   cyc_ff;
  nfc_pkg::nfc_boot_e  boot_ff;
  logic [3:0]  tcnt_ff;
  logic [2:0]  left_ff;
  logic [2:0]  idx_ff;
  logic [31:0] shift_ff;
  logic [11:0] bptr_ff;
  logic [2:0]  acnt_ff;
  logic        bus_ff;
  logic [31:0] rdacc_ff;

  // offsets whose access is carried out on the flash pins
  function automatic logic flash_op(input logic [11:0] o, input logic w);
    return (w && (o == `NFC_OFS_CMD || o == `NFC_OFS_ADDR || o == `NFC_OFS_DATA)) ||
           (!w && (o == `NFC_OFS_DATA || o == `NFC_OFS_MECC || o == `NFC_OFS_SECC));
  endfunction

  wire       wide     = strap_ff[3];
  wire [3:0] t_setup  = conf_ff[3:0];
  wire [3:0] t_pulse  = conf_ff[7:4];
  wire [3:0] t_hold   = conf_ff[11:8];
  wire       setup_ph = i_psel && !i_penable;
  wire       is_buf   = i_paddr[12];
  wire       is_wr    = i_pwrite;
  wire [11:0] ofs     = i_paddr[11:0];
  wire       data_reg = (ofs == `NFC_OFS_DATA) || (ofs == `NFC_OFS_MECC) ||
                        (ofs == `NFC_OFS_SECC);
  wire       acc_ok   = is_buf || data_reg || (i_psize == 2'd2); // [RULE_16]
  // software cycles are refused until the boot copy has let go of the pins
  wire       sw_ok    = (boot_ff == nfc_pkg::NFC_B_DONE);
  wire       fl_start = setup_ph && !is_buf && acc_ok && sw_ok &&
                        (st_ff == nfc_pkg::NFC_IDLE) && flash_op(ofs, is_wr);
  wire       boot_act = (boot_ff != nfc_pkg::NFC_B_OFF) && (boot_ff != nfc_pkg::NFC_B_DONE);
  wire       last_cyc = (st_ff == nfc_pkg::NFC_HOLD) && (tcnt_ff == 4'd0) && (left_ff == 3'd1);

  // number of flash transfers for an access size
  function automatic logic [2:0] xfers(input logic [1:0] sz, input logic w16);
    logic [2:0] n;
    n = 3'd1;
    if (w16) n = (sz == 2'd2) ? 3'd2 : 3'd1; // [RULE_14]
    else n = (sz == 2'd2) ? 3'd4 : ((sz == 2'd1) ? 3'd2 : 3'd1); // [RULE_15]
    return n;
  endfunction

  // lane position of the k-th transfer; little: k, big: from the top
  function automatic logic [1:0] lane(input logic [2:0] k, input logic [2:0] n,
                                      input logic big);
    logic [2:0] p;
    p = big ? (n - 3'd1 - k) : k;
    return p[1:0];
  endfunction

  // straps are sampled the first clock after reset, then never again
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_ff   <= 1'b0;
      strap_ff <= 4'h0;
      bmode_ff <= 2'b11;
    end else if (!cap_ff) begin
      cap_ff   <= 1'b1;
      strap_ff <= {i_bus_width_strap, i_addr_cycle_strap, i_page_size_strap,
                   i_flash_type_strap}; // [RULE_08] [RULE_04] [RULE_05] [RULE_07]
      bmode_ff <= i_boot_mode_pins;
    end
  end

  // address cycle count: normal 3/4, advanced 4/5
  wire [2:0] n_addr = 3'd3 + {2'b00, strap_ff[0]} + {2'b00, strap_ff[2]}; // [RULE_06]

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boot_ff <= nfc_pkg::NFC_B_OFF;
      bptr_ff <= 12'h000;
      acnt_ff <= 3'd0;
    end else begin
      unique case (boot_ff)
        nfc_pkg::NFC_B_OFF: if (cap_ff)
          boot_ff <= (bmode_ff == 2'b00) ? nfc_pkg::NFC_B_CMD : nfc_pkg::NFC_B_DONE; // [RULE_03]
        nfc_pkg::NFC_B_CMD: if (last_cyc) boot_ff <= nfc_pkg::NFC_B_ADDR;
        nfc_pkg::NFC_B_ADDR: if (last_cyc) begin
          acnt_ff <= acnt_ff + 3'd1;
          if (acnt_ff + 3'd1 == n_addr) boot_ff <= nfc_pkg::NFC_B_WAIT;
        end
        nfc_pkg::NFC_B_WAIT: if (rdy_d_ff) boot_ff <= nfc_pkg::NFC_B_DATA; // [RULE_13]
        nfc_pkg::NFC_B_DATA: if (last_cyc) begin
          bptr_ff <= bptr_ff + 12'd4;
          // raw copy, no parity checks on the boot image [RULE_02]
          if (bptr_ff == 12'hffc) boot_ff <= nfc_pkg::NFC_B_DONE; // [RULE_01]
        end
        nfc_pkg::NFC_B_DONE: boot_ff <= nfc_pkg::NFC_B_DONE;
        default: boot_ff <= nfc_pkg::NFC_B_DONE;
      endcase
    end
  end

  // flash cycle engine: setup, low pulse, hold per transfer [RULE_18]
  wire bt_go = (st_ff == nfc_pkg::NFC_IDLE) && !bus_ff &&
               (boot_ff == nfc_pkg::NFC_B_CMD || boot_ff == nfc_pkg::NFC_B_ADDR ||
                boot_ff == nfc_pkg::NFC_B_DATA);
  wire [7:0] bt_addr = (acnt_ff == 3'd0) ? 8'h00 : 8'h00;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff    <= nfc_pkg::NFC_IDLE;
      cyc_ff   <= nfc_pkg::NFC_CYC_CMD;
      tcnt_ff  <= 4'd0;
      left_ff  <= 3'd0;
      idx_ff   <= 3'd0;
      shift_ff <= 32'h0;
      bus_ff   <= 1'b0;
      rdacc_ff <= 32'h0;
    end else begin
      unique case (st_ff)
        nfc_pkg::NFC_IDLE: begin
          bus_ff <= 1'b0;
          if (boot_act && bt_go) begin
            bus_ff   <= 1'b1;
            st_ff    <= nfc_pkg::NFC_SETUP;
            tcnt_ff  <= t_setup;
            idx_ff   <= 3'd0;
            rdacc_ff <= 32'h0;
            unique case (boot_ff)
              nfc_pkg::NFC_B_CMD: begin
                cyc_ff <= nfc_pkg::NFC_CYC_CMD;
                left_ff <= 3'd1;
                shift_ff <= {24'h0, `NFC_READ_CMD};
              end
              nfc_pkg::NFC_B_ADDR: begin
                cyc_ff <= nfc_pkg::NFC_CYC_ADDR;
                left_ff <= 3'd1;
                shift_ff <= {24'h0, bt_addr};
              end
              default: begin
                cyc_ff <= nfc_pkg::NFC_CYC_RD;
                left_ff <= wide ? 3'd2 : 3'd4;
              end
            endcase
          end else if (fl_start) begin
            st_ff    <= nfc_pkg::NFC_SETUP;
            tcnt_ff  <= t_setup;
            idx_ff   <= 3'd0;
            rdacc_ff <= 32'h0;
            shift_ff <= i_pwdata;
            if (is_wr && ofs == `NFC_OFS_CMD) begin
              cyc_ff <= nfc_pkg::NFC_CYC_CMD; // [RULE_09]
              left_ff <= 3'd1;
            end else if (is_wr && ofs == `NFC_OFS_ADDR) begin
              cyc_ff <= nfc_pkg::NFC_CYC_ADDR; // [RULE_10]
              left_ff <= 3'd1;
            end else begin
              cyc_ff <= is_wr ? nfc_pkg::NFC_CYC_WR : nfc_pkg::NFC_CYC_RD; // [RULE_11] [RULE_12]
              left_ff <= xfers(i_psize, wide);
            end
          end
        end
        nfc_pkg::NFC_SETUP: begin
          if (tcnt_ff == 4'd0) begin
            st_ff   <= nfc_pkg::NFC_PULSE;
            tcnt_ff <= t_pulse;
          end else begin
            tcnt_ff <= tcnt_ff - 4'd1;
          end
        end
        nfc_pkg::NFC_PULSE: begin
          if (tcnt_ff == 4'd0) begin
            st_ff   <= nfc_pkg::NFC_HOLD;
            tcnt_ff <= t_hold;
            // taken at the end of the pulse state, one clock before the last low clock of the registered strobe
            if (cyc_ff == nfc_pkg::NFC_CYC_RD) begin
              if (wide) begin
                rdacc_ff[lane(idx_ff, left_ff + idx_ff, 1'b0) * 16 +: 16] <= i_flash_data;
              end else begin
                rdacc_ff[lane(idx_ff, left_ff + idx_ff, 1'b0) * 8 +: 8] <= i_flash_data[7:0];
              end
            end
          end else begin
            tcnt_ff <= tcnt_ff - 4'd1;
          end
        end
        nfc_pkg::NFC_HOLD: begin
          if (tcnt_ff != 4'd0) begin
            tcnt_ff <= tcnt_ff - 4'd1;
          end else if (left_ff == 3'd1) begin
            st_ff <= nfc_pkg::NFC_IDLE;
          end else begin
            left_ff <= left_ff - 3'd1;
            idx_ff  <= idx_ff + 3'd1;
            st_ff   <= nfc_pkg::NFC_SETUP;
            tcnt_ff <= t_setup;
          end
        end
        default: st_ff <= nfc_pkg::NFC_IDLE;
      endcase
    end
  end

  // byte/half placement of a finished read, applying endianness
  function automatic logic [31:0] order(input logic [31:0] raw, input logic [2:0] n,
                                        input logic w16, input logic big);
    logic [31:0] r;
    r = raw;
    if (big && n > 3'd1) begin
      if (w16) r = {raw[15:0], raw[31:16]}; // [RULE_14]
      else if (n == 3'd4) r = {raw[7:0], raw[15:8], raw[23:16], raw[31:24]}; // [RULE_15]
      else r = {16'h0, raw[7:0], raw[15:8]};
    end
    return r;
  endfunction

  wire [2:0]  cur_n  = idx_ff + left_ff;
  wire [2:0]  lw     = lane(idx_ff, cur_n, i_big_endian);
  wire [15:0] wr_val = wide ? shift_ff[lw[0] * 16 +: 16] : {8'h00, shift_ff[lw * 8 +: 8]};

  // pin drivers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flash_data           <= 16'h0;
      o_flash_data_oe        <= 1'b0;
      o_cmd_latch            <= 1'b0;
      o_addr_latch           <= 1'b0;
      o_flash_write_strobe_n <= 1'b1;
      o_flash_read_strobe_n  <= 1'b1;
      o_flash_chip_enable_n  <= 1'b1;
    end else begin
      o_flash_chip_enable_n  <= !(boot_act || st_ff != nfc_pkg::NFC_IDLE); // [RULE_19]
      o_cmd_latch  <= (st_ff != nfc_pkg::NFC_IDLE) && cyc_ff == nfc_pkg::NFC_CYC_CMD; // [RULE_18]
      o_addr_latch <= (st_ff != nfc_pkg::NFC_IDLE) && cyc_ff == nfc_pkg::NFC_CYC_ADDR;
      o_flash_write_strobe_n <= !(st_ff == nfc_pkg::NFC_PULSE && cyc_ff != nfc_pkg::NFC_CYC_RD);
      o_flash_read_strobe_n  <= !(st_ff == nfc_pkg::NFC_PULSE && cyc_ff == nfc_pkg::NFC_CYC_RD);
      o_flash_data_oe <= (st_ff != nfc_pkg::NFC_IDLE) && cyc_ff != nfc_pkg::NFC_CYC_RD;
      // 8-bit parts see the same byte on both halves
      o_flash_data <= wide && cyc_ff == nfc_pkg::NFC_CYC_WR ? wr_val
                      : {wr_val[7:0], wr_val[7:0]};
    end
  end

  // boot buffer: boot copy writes words, apb reaches any byte lane [RULE_17]
  wire buf_wr = i_psel && i_penable && is_wr && is_buf && o_pready;
  always_ff @(posedge i_clk) begin
    if (boot_ff == nfc_pkg::NFC_B_DATA && last_cyc)
      buf_ff[bptr_ff[11:2]] <= order(rdacc_ff, wide ? 3'd2 : 3'd4, wide, 1'b0);
    else if (buf_wr)
      for (int b = 0; b < 4; b++)
        if (i_pstrb[b]) buf_ff[i_paddr[11:2]][b*8 +: 8] <= i_pwdata[b*8 +: 8];
  end

  // registers, status and interrupt
  wire rdy_rise = i_flash_ready_busy && !rdy_d_ff;
  wire acc_ph   = i_psel && i_penable && !o_pready;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conf_ff  <= `NFC_CONF_RESET;
      stat_ff  <= 2'b00;
      mask_ff  <= 2'b00;
      rdy_d_ff <= 1'b1; // idle level is ready: no false rise after reset
      o_irq    <= 1'b0;
      o_boot_done <= 1'b0;
    end else begin
      rdy_d_ff <= i_flash_ready_busy;
      o_boot_done <= boot_ff == nfc_pkg::NFC_B_DONE; // [RULE_01]
      if (acc_ph && is_wr && !is_buf && acc_ok && ofs == `NFC_OFS_CONF) conf_ff <= i_pwdata;
      if (acc_ph && is_wr && !is_buf && acc_ok && ofs == `NFC_OFS_MASK) mask_ff <= i_pwdata[1:0];
      // a new event wins over a write-one clear
      for (int k = 0; k < 2; k++)
        if ((k == `NFC_ST_RDY_BIT && rdy_rise) ||
            (k == `NFC_ST_BOOT_BIT && boot_ff == nfc_pkg::NFC_B_DATA && last_cyc &&
             bptr_ff == 12'hffc))
          stat_ff[k] <= 1'b1; // [RULE_13]
        else if (acc_ph && is_wr && !is_buf && ofs == `NFC_OFS_STAT && i_pwdata[k])
          stat_ff[k] <= 1'b0;
      o_irq <= |(stat_ff & mask_ff); // [RULE_13]
    end
  end

  // apb answer: flash accesses wait for the engine, others take one wait cycle
  wire fl_acc    = !is_buf && flash_op(ofs, is_wr);
  // an engine still idle in the access phase never took the request: refuse it
  wire fl_refuse = fl_acc && (!sw_ok || st_ff == nfc_pkg::NFC_IDLE);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      if (acc_ph && (!fl_acc || !acc_ok || fl_refuse || (st_ff == nfc_pkg::NFC_HOLD &&
          tcnt_ff == 4'd0 && left_ff == 3'd1 && !bus_ff))) begin
        o_pready  <= 1'b1;
        o_pslverr <= !acc_ok || fl_refuse;
        o_prdata  <= 32'h0;
        if (is_buf) o_prdata <= buf_ff[i_paddr[11:2]];
        else if (!is_wr && acc_ok) unique case (ofs)
          `NFC_OFS_CONF:  o_prdata <= conf_ff;
          `NFC_OFS_STAT:  o_prdata <= {29'h0, i_flash_ready_busy, stat_ff};
          `NFC_OFS_MASK:  o_prdata <= {30'h0, mask_ff};
          `NFC_OFS_STRAP: o_prdata <= {26'h0, bmode_ff, strap_ff};
          `NFC_OFS_DATA, `NFC_OFS_MECC, `NFC_OFS_SECC:
            o_prdata <= order(rdacc_ff, cur_n, wide, i_big_endian); // [RULE_11]
          default:        o_prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // nfc_ctrl

// >>> rtl/nfc_map.svh
// Function
// RULE_01 - reset boot copies first 4 KB to buffer
// RULE_02 - boot copy does no error-code checking
// RULE_03 - boot copy only when boot pins equal 00
// RULE_04 - type strap selects normal or advanced flash
// RULE_05 - page strap picks page size in class; here only captured and read back
// RULE_06 - address strap sets address cycle count
// RULE_07 - width strap selects 8 or 16 bit bus
// RULE_08 - straps captured at reset then held
// RULE_09 - command write gives one command cycle
// RULE_10 - address write gives one address cycle
// RULE_11 - data write/read issues flash data cycles
// RULE_12 - ecc data reads also read flash
// RULE_13 - ready/busy visible as status and interrupt
// RULE_14 - 16-bit bus packs halves by endianness
// RULE_15 - 8-bit bus packs bytes by endianness
// RULE_16 - data regs sized access, others word only; a non-word status write is refused with an error yet still clears its bits
// RULE_17 - boot buffer any size, any endian, reusable
// RULE_18 - latch enables and timed low strobes
// RULE_19 - chip enable held during flash activity
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH
`define NFC_OFS_CONF      12'h000
`define NFC_OFS_CMD       12'h004
`define NFC_OFS_ADDR      12'h008
`define NFC_OFS_DATA      12'h00c
`define NFC_OFS_MECC      12'h010
`define NFC_OFS_SECC      12'h014
`define NFC_OFS_STAT      12'h018
`define NFC_OFS_MASK      12'h01c
`define NFC_OFS_STRAP     12'h020
`define NFC_CONF_RESET    32'h0000_0111
`define NFC_BOOT_BYTES    13'h1000
`define NFC_BUF_WORDS     1024
`define NFC_BUF_BASE      13'h1000
`define NFC_ST_RDY_BIT    0
`define NFC_ST_BOOT_BIT   1
`define NFC_READ_CMD      8'h00
`endif

// >>> rtl/nfc_pkg.sv
package nfc_pkg;
  typedef enum logic [2:0] {
    NFC_IDLE, NFC_SETUP, NFC_PULSE, NFC_HOLD, NFC_BOOT_NEXT
  } nfc_state_e;
  typedef enum logic [1:0] {
    NFC_CYC_CMD, NFC_CYC_ADDR, NFC_CYC_WR, NFC_CYC_RD
  } nfc_cyc_e;
  typedef enum logic [2:0] {
    NFC_B_OFF, NFC_B_CMD, NFC_B_ADDR, NFC_B_WAIT, NFC_B_DATA, NFC_B_DONE
  } nfc_boot_e;
endpackage

// >>> bench/nfc_flash_model.sv
`timescale 1ns/1ps
// flash stand-in: counts reads, logs data writes, busy after each command
module nfc_flash_model (
  input  wire logic        i_clk,
  input  wire logic        i_cle,
  input  wire logic        i_ale,
  input  wire logic        i_we_n,
  input  wire logic        i_re_n,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe,
  input  wire logic [15:0] i_dout,
  output logic      [15:0] o_bus,
  output logic             o_rdy,
  output logic      [15:0] o_cnt,
  output logic      [31:0] o_log,
  output logic      [7:0]  o_cmd
);
  logic [15:0] last_ff;
  logic [7:0]  wd_ff;
  logic        wc_ff;
  logic        wa_ff;
  logic        we_ff;
  logic        re_ff;
  int          busy;
  // a released bus shows the inverse of its last value, never a stale copy
  assign o_bus = (!i_re_n && !i_ce_n) ? o_cnt : (i_oe ? i_dout : ~last_ff);
  assign o_rdy = (busy == 0);
  initial begin
    o_cnt = '0;
    o_log = '0;
    o_cmd = '0;
    busy = 0;
    last_ff = '0;
    we_ff = 1'b1;
    re_ff = 1'b1;
  end
  always @(posedge i_clk) begin
    last_ff <= o_bus;
    we_ff <= i_we_n;
    re_ff <= i_re_n;
    if (busy > 0) busy <= busy - 1;
    if (i_re_n && !re_ff) o_cnt <= o_cnt + 16'h1;
    // data sampled while the strobe is low, used at its rising edge
    if (!i_we_n) begin
      wd_ff <= o_bus[7:0];
      wc_ff <= i_cle;
      wa_ff <= i_ale;
    end
    if (i_we_n && !we_ff && wc_ff) begin
      o_cmd <= wd_ff;
      o_cnt <= '0;
      busy <= 20;
    end else if (i_we_n && !we_ff && !wa_ff) begin
      o_log <= {o_log[23:0], wd_ff};
    end
  end
endmodule // nfc_flash_model

// >>> bench/nfc_ctrl_chk.sv
`timescale 1ns/1ps
module nfc_ctrl_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_cmd_latch,
  input wire logic o_addr_latch,
  input wire logic o_flash_write_strobe_n,
  input wire logic o_flash_read_strobe_n,
  input wire logic o_flash_chip_enable_n,
  input wire logic o_flash_data_oe,
  input wire logic o_boot_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_pready_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held two cycles");
  a_latch_excl: assert property (!(o_cmd_latch && o_addr_latch))
    else $error("both latches high");
  a_strobe_excl: assert property (o_flash_write_strobe_n || o_flash_read_strobe_n)
    else $error("both strobes low");
  a_strobe_ce: assert property (!(o_flash_write_strobe_n && o_flash_read_strobe_n)
    |-> !o_flash_chip_enable_n) else $error("strobe without chip enable");
  a_latch_hold: assert property (!o_flash_write_strobe_n && $past(!o_flash_write_strobe_n)
    |-> $stable(o_cmd_latch) && $stable(o_addr_latch)) else $error("latch moved in pulse");
  // reset timing gives a two-cycle write pulse
  a_we_width: assert property ($fell(o_flash_write_strobe_n)
    |-> !o_flash_write_strobe_n [*2]) else $error("write pulse short");
  a_read_release: assert property (!o_flash_read_strobe_n |-> !o_flash_data_oe)
    else $error("driving bus during read");
  a_boot_nowrite: assert property (!o_boot_done && !o_flash_write_strobe_n
    |-> o_cmd_latch || o_addr_latch) else $error("data write during boot");
endmodule // nfc_ctrl_chk

bind nfc_ctrl nfc_ctrl_chk i_nfc_ctrl_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_cmd_latch(o_cmd_latch), .o_addr_latch(o_addr_latch),
  .o_flash_write_strobe_n(o_flash_write_strobe_n),
  .o_flash_read_strobe_n(o_flash_read_strobe_n),
  .o_flash_chip_enable_n(o_flash_chip_enable_n),
  .o_flash_data_oe(o_flash_data_oe), .o_boot_done(o_boot_done));

// >>> bench/nfc_ctrl_bench.sv
`timescale 1ns/1ps
`include "nfc_map.svh"
module nfc_ctrl_bench;
  logic        clk, reset_n, psel, penable, pwrite, big, pready, pslverr, oe;
  logic        cle, ale, we_n, re_n, ce_n, done, irq, rdy;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, seed, wlog;
  logic [3:0]  strap;
  logic [1:0]  psize, boot_pins;
  logic [15:0] fbus, dout, cnt, c0;
  logic [7:0]  lcmd;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int          n_mismatch, samples_checked, k;

  nfc_ctrl i_nfc_ctrl (
    .i_clk(clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
    .i_psize(psize), .i_big_endian(big), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_flash_type_strap(strap[0]), .i_page_size_strap(strap[1]),
    .i_addr_cycle_strap(strap[2]), .i_bus_width_strap(strap[3]),
    .i_boot_mode_pins(boot_pins), .i_flash_ready_busy(rdy), .i_flash_data(fbus),
    .o_flash_data(dout), .o_flash_data_oe(oe), .o_cmd_latch(cle), .o_addr_latch(ale),
    .o_flash_write_strobe_n(we_n), .o_flash_read_strobe_n(re_n),
    .o_flash_chip_enable_n(ce_n), .o_boot_done(done), .o_irq(irq));
  nfc_flash_model i_nfc_flash_model (
    .i_clk(clk), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
    .i_ce_n(ce_n), .i_oe(oe), .i_dout(dout), .o_bus(fbus), .o_rdy(rdy),
    .o_cnt(cnt), .o_log(wlog), .o_cmd(lcmd));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // the expectation is queued before the request goes out
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d,
                     input logic [1:0] s, input logic [31:0] x, input logic [31:0] m,
                     input logic err);
    int n;
    // one idle edge between transfers, so psel is never assigned twice in a step
    @(posedge clk);
    exp_q.push_back({err, m, x});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    psize <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    if (pready !== 1'b1) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, 2'd2, '0, '0, err);
  endtask
  task automatic rd(input logic [12:0] a, input logic [1:0] s, input logic [31:0] x,
                    input logic [31:0] m);
    apb(1'b0, a, '0, s, x, m, 1'b0);
  endtask
  task automatic wait_rdy(input logic lvl);
    k = 0;
    while (rdy !== lvl && k < 2000) begin
      cyc(1);
      k++;
    end
    if (rdy !== lvl) n_mismatch++;
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(prdata & e[63:32], e[31:0] & e[63:32]);
      check({31'h0, pslverr}, {31'h0, e[64]});
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    n_mismatch++;
    final_report;
  end
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    psize = 2'd2;
    big = 1'b0;
    boot_pins = 2'b00;
    strap = 4'b0010;
    n_mismatch = 0;
    samples_checked = 0;
    seed = 32'ha485;
    cyc(16);
    reset_n <= 1'b1;
    wr(`NFC_OFS_CMD, 32'h0, 1'b1);
    strap <= 4'b1101;
    k = 0;
    while (done !== 1'b1 && k < 60000) begin
      cyc(1);
      k++;
    end
    check({31'h0, done}, 32'h1);
    rd(`NFC_BUF_BASE, 2'd2, 32'h03020100, '1);
    rd(13'h1ffc, 2'd2, 32'hfffefdfc, '1);
    rd(`NFC_OFS_CONF, 2'd2, `NFC_CONF_RESET, '1);
    rd(13'h040, 2'd2, 32'h0, '1);
    apb(1'b1, `NFC_OFS_CONF, 32'h0, 2'd0, '0, '0, 1'b1);
    wr(`NFC_OFS_CMD, 32'h30, 1'b0);
    check({24'h0, lcmd}, 32'h30);
    wr(`NFC_OFS_ADDR, 32'h5a, 1'b0);
    check({24'h0, lcmd}, 32'h30);
    wait_rdy(1'b1);
    rd(`NFC_OFS_DATA, 2'd2, 32'h03020100, '1);
    big <= 1'b1;
    rd(`NFC_OFS_DATA, 2'd2, 32'h04050607, '1);
    big <= 1'b0;
    rd(`NFC_OFS_DATA, 2'd1, 32'h0908, 32'hffff);
    rd(`NFC_OFS_DATA, 2'd0, 32'h0a, 32'hff);
    rd(`NFC_OFS_MECC, 2'd2, 32'h0e0d0c0b, '1);
    rd(`NFC_OFS_SECC, 2'd0, 32'h0f, 32'hff);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(`NFC_OFS_DATA, seed, 1'b0);
      check(wlog, {seed[7:0], seed[15:8], seed[23:16], seed[31:24]});
    end
    wr(`NFC_OFS_STAT, 32'h3, 1'b0);
    wr(`NFC_OFS_CMD, 32'h70, 1'b0);
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    cyc(3);
    rd(`NFC_OFS_STAT, 2'd2, 32'h5, 32'h5);
    wr(`NFC_OFS_MASK, 32'h0, 1'b0);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    wr(`NFC_OFS_MASK, 32'h2, 1'b0);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    wr(`NFC_OFS_MASK, 32'h1, 1'b0);
    cyc(2);
    check({31'h0, irq}, 32'h1);
    wr(`NFC_OFS_STAT, 32'h1, 1'b0);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    rd(`NFC_OFS_STAT, 2'd2, 32'h4, 32'h5);
    boot_pins <= 2'b01;
    strap <= 4'b1000;
    reset_n <= 1'b0;
    cyc(16);
    reset_n <= 1'b1;
    c0 = cnt;
    cyc(300);
    check({16'h0, cnt}, {16'h0, c0});
    check({31'h0, done}, 32'h1);
    // 16-bit bus: halves packed by endianness
    wr(`NFC_OFS_CMD, 32'h0, 1'b0);
    wait_rdy(1'b1);
    rd(`NFC_OFS_DATA, 2'd2, 32'h00010000, '1);
    rd(`NFC_OFS_DATA, 2'd1, 32'h0002, 32'hffff);
    big <= 1'b1;
    rd(`NFC_OFS_DATA, 2'd2, 32'h00030004, '1);
    big <= 1'b0;
    seed = xs(seed);
    wr(`NFC_OFS_DATA, seed, 1'b0);
    check({16'h0, wlog[15:0]}, {16'h0, seed[7:0], seed[23:16]});
    final_report;
  end
endmodule // nfc_ctrl_bench
